// [mad_datapath.sv]
/*
 * Multiply-accumulate datapath with an AXI4-Lite register slave.
 * Assumes one 100 MHz clock, a synchronous active-low reset and
 * a bus master on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - add-previous adds old product, shifted, to accumulator.
// - add-previous loads signed multiplicand times signed operand into product.
// - subtract-previous subtracts old shifted product from accumulator.
// - subtract-previous also loads signed 16x16 product into product register.
// - add/subtract-previous and byte-constant accumulator form set zero flag when result is zero.
// - add/subtract-previous copy accumulator bit 31 into negative flag.
// - add/subtract-previous set carry from the accumulate step, else clear.
// - accumulate overflow sets overflow flag; no overflow leaves it unchanged.
// - saturation off: overflow tally counts up or down on overflow.
// - saturation on: overflow forces accumulator to largest positive or negative.
// - shift selector: left shifts zero-fill, right shifts are arithmetic.
// - after repeat prefix N, add/subtract-previous run N+1 cycles.
// - repeated runs keep final flags; overflow flag sticks from any pass.
// - byte-constant accumulator form: signed multiplicand times zero-extended byte.
// - byte-constant accumulator form sets negative flag from bit 31.
// - byte-constant product form writes product, flags untouched.
// - non-repeatable forms after repeat prefix clear counter, run once.
module mad_datapath (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ========================================
	// helpers
	function automatic logic isMapped(input logic [5:0] a);
		return (a <= mad_pkg::OFF_STATUS) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
						  input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] shiftProd(input logic [31:0] p, input logic [2:0] sel);
		case (sel)
			3'h0: return {p[30:0], 1'b0};
			3'h1: return p;
			default: return $signed(p) >>> (sel - 3'h1);
		endcase
	endfunction

	mad_pkg::mad_state_s st_reg;
	mad_pkg::mad_state_s st_next;
	logic [31:0]         shiftedProd;
	logic [31:0]         signedProd;
	logic [31:0]         unsignedProd;
	logic [31:0]         byteProd;
	logic [31:0]         addend;
	logic [32:0]         sum33;
	logic [31:0]         accSat;
	logic                isSub;
	logic                posOvf;
	logic                negOvf;
	logic                awTake;
	logic                wTake;
	logic                writeFire;
	logic                startCmd;
	logic                startRepeatable;
	logic [5:0]          wAddr;
	logic [31:0]         wVal;
	logic [3:0]          wStb;
	logic [31:0]         rdVal;
	mad_pkg::mad_op_e    cmdOp;

	// ========================================
	// arithmetic, always from the registered state
	// old product feeds accumulate
	assign shiftedProd  = shiftProd(st_reg.core.prod, st_reg.core.shiftSel);
	assign signedProd   = $signed({{16{st_reg.core.mcand[15]}}, st_reg.core.mcand})
			    * $signed({{16{st_reg.core.operand[15]}}, st_reg.core.operand});
	assign unsignedProd = {16'h0000, st_reg.core.mcand} * {16'h0000, st_reg.core.operand};
	assign byteProd     = $signed({{16{st_reg.core.mcand[15]}}, st_reg.core.mcand})
			    * $signed({24'h000000, st_reg.core.imm});
	assign isSub        = (st_reg.core.op == mad_pkg::MUL_SUB_PREV_OP);
	assign addend       = isSub ? ~shiftedProd : shiftedProd;
	assign sum33        = {1'b0, st_reg.core.acc} + {1'b0, addend} + {32'h00000000, isSub};
	assign posOvf       = !st_reg.core.acc[31] && !addend[31] && sum33[31];
	assign negOvf       = st_reg.core.acc[31] && addend[31] && !sum33[31];
	assign accSat       = (st_reg.core.saturate && posOvf) ? mad_pkg::SAT_POS :
			      (st_reg.core.saturate && negOvf) ? mad_pkg::SAT_NEG : sum33[31:0];

	// ========================================
	// bus side
	assign awTake    = s_axi_awvalid && st_reg.axi.awReady;
	assign wTake     = s_axi_wvalid && st_reg.axi.wReady;
	assign wAddr     = st_reg.axi.awHeld ? st_reg.axi.awAddr : s_axi_awaddr;
	assign wVal      = st_reg.axi.wHeld ? st_reg.axi.wData : s_axi_wdata;
	assign wStb      = st_reg.axi.wHeld ? st_reg.axi.wStrb : s_axi_wstrb;
	assign writeFire = (st_reg.axi.awHeld || awTake) && (st_reg.axi.wHeld || wTake);
	assign cmdOp     = mad_pkg::mad_op_e'(wVal[mad_pkg::CMD_OP_LSB +: 3]);
	// a command whose op field is out of range or none is refused
	assign startCmd  = writeFire && isMapped(wAddr) && (wAddr == mad_pkg::OFF_CMD)
			 && (st_reg.core.state == mad_pkg::ST_IDLE) && wStb[0]
			 && (cmdOp >= mad_pkg::MUL_ADD_PREV_OP) && (cmdOp <= mad_pkg::MUL_UNSIGNED_OP);
	assign startRepeatable = startCmd && st_reg.core.armed
			 && (cmdOp == mad_pkg::MUL_ADD_PREV_OP || cmdOp == mad_pkg::MUL_SUB_PREV_OP);

	always_comb begin
		rdVal = 32'h00000000;
		case (s_axi_araddr)
			mad_pkg::OFF_CTRL: begin
				rdVal[mad_pkg::CTRL_SHIFT_LSB +: 3] = st_reg.core.shiftSel;
				rdVal[mad_pkg::CTRL_SAT_BIT] = st_reg.core.saturate;
			end
			mad_pkg::OFF_MCAND: rdVal[15:0] = st_reg.core.mcand;
			mad_pkg::OFF_ACC: rdVal = st_reg.core.acc;
			mad_pkg::OFF_PROD: rdVal = st_reg.core.prod;
			mad_pkg::OFF_FLAGS: begin
				rdVal[mad_pkg::FLAG_Z_BIT] = st_reg.core.flagZ;
				rdVal[mad_pkg::FLAG_N_BIT] = st_reg.core.flagN;
				rdVal[mad_pkg::FLAG_C_BIT] = st_reg.core.flagC;
				rdVal[mad_pkg::FLAG_V_BIT] = st_reg.core.flagV;
				rdVal[mad_pkg::FLAG_TALLY_LSB +: 6] = st_reg.core.tally;
			end
			mad_pkg::OFF_REPEAT: rdVal[7:0] = st_reg.core.repCount;
			mad_pkg::OFF_CMD: begin
				rdVal[mad_pkg::CMD_OP_LSB +: 3] = st_reg.core.op;
				rdVal[mad_pkg::CMD_IMM_LSB +: 8] = st_reg.core.imm;
				rdVal[mad_pkg::CMD_OPND_LSB +: 16] = st_reg.core.operand;
			end
			mad_pkg::OFF_STATUS: begin
				rdVal[mad_pkg::STAT_BUSY_BIT] = (st_reg.core.state == mad_pkg::ST_RUN);
				rdVal[mad_pkg::STAT_ARMED_BIT] = st_reg.core.armed;
				rdVal[mad_pkg::STAT_COUNT_LSB +: 8] = st_reg.core.repCount;
			end
			default: rdVal = 32'h00000000;
		endcase
	end

	// ========================================
	// next state
	always_comb begin
		st_next = st_reg;
		// write channel: hold whichever half came first
		if (awTake && !writeFire) begin
			st_next.axi.awHeld = 1'b1;
			st_next.axi.awAddr = s_axi_awaddr;
		end
		if (wTake && !writeFire) begin
			st_next.axi.wHeld = 1'b1;
			st_next.axi.wData = s_axi_wdata;
			st_next.axi.wStrb = s_axi_wstrb;
		end
		if (st_reg.axi.bValid && s_axi_bready) begin
			st_next.axi.bValid = 1'b0;
		end
		if (writeFire) begin
			st_next.axi.awHeld = 1'b0;
			st_next.axi.wHeld  = 1'b0;
			st_next.axi.bValid = 1'b1;
			st_next.axi.bResp  = mad_pkg::RESP_OKAY;
			// registers are frozen while a command runs
			if (!isMapped(wAddr) || st_reg.core.state != mad_pkg::ST_IDLE) begin
				st_next.axi.bResp = mad_pkg::RESP_SLVERR;
			end else begin
				case (wAddr)
					mad_pkg::OFF_CTRL: if (wStb[0]) begin
						st_next.core.shiftSel = wVal[mad_pkg::CTRL_SHIFT_LSB +: 3];
						st_next.core.saturate = wVal[mad_pkg::CTRL_SAT_BIT];
					end
					mad_pkg::OFF_MCAND: st_next.core.mcand =
						16'(mergeStrb({16'h0000, st_reg.core.mcand}, wVal, wStb));
					mad_pkg::OFF_ACC: st_next.core.acc = mergeStrb(st_reg.core.acc, wVal, wStb);
					mad_pkg::OFF_PROD: st_next.core.prod = mergeStrb(st_reg.core.prod, wVal, wStb);
					mad_pkg::OFF_FLAGS: if (wStb[0]) begin
						st_next.core.flagZ = wVal[mad_pkg::FLAG_Z_BIT];
						st_next.core.flagN = wVal[mad_pkg::FLAG_N_BIT];
						st_next.core.flagC = wVal[mad_pkg::FLAG_C_BIT];
						st_next.core.flagV = wVal[mad_pkg::FLAG_V_BIT];
						st_next.core.tally[3:0] = wVal[7:4];
					end
					mad_pkg::OFF_REPEAT: if (wStb[0]) begin
						st_next.core.repCount = wVal[7:0];
						st_next.core.armed = 1'b1;
					end
					mad_pkg::OFF_CMD: if (!startCmd) begin
						st_next.axi.bResp = mad_pkg::RESP_SLVERR;
					end
					default: st_next.axi.bResp = mad_pkg::RESP_OKAY;
				endcase
				if (wAddr == mad_pkg::OFF_FLAGS && wStb[1]) begin
					st_next.core.tally[5:4] = wVal[9:8];
				end
			end
		end
		st_next.axi.awReady = !st_next.axi.awHeld && !st_next.axi.bValid;
		st_next.axi.wReady  = !st_next.axi.wHeld && !st_next.axi.bValid;
		// read channel
		if (st_reg.axi.rValid && s_axi_rready) begin
			st_next.axi.rValid  = 1'b0;
		end
		if (s_axi_arvalid && st_reg.axi.arReady) begin
			st_next.axi.rValid  = 1'b1;
			st_next.axi.rData   = rdVal;
			st_next.axi.rResp   = isMapped(s_axi_araddr) ? mad_pkg::RESP_OKAY : mad_pkg::RESP_SLVERR;
		end
		// derived, so it rises on the first edge after reset and after each taken response
		st_next.axi.arReady = !st_next.axi.rValid;
		// datapath
		case (st_reg.core.state)
			mad_pkg::ST_IDLE: if (startCmd) begin
				st_next.core.state   = mad_pkg::ST_RUN;
				st_next.core.op      = cmdOp;
				st_next.core.imm     = wVal[mad_pkg::CMD_IMM_LSB +: 8];
				st_next.core.operand = wVal[mad_pkg::CMD_OPND_LSB +: 16];
				st_next.core.armed   = 1'b0;
				if (!startRepeatable) begin
					st_next.core.repCount = 8'h00;
				end
			end
			mad_pkg::ST_RUN: begin
				case (st_reg.core.op)
					mad_pkg::MUL_ADD_PREV_OP, mad_pkg::MUL_SUB_PREV_OP: begin
						st_next.core.acc  = accSat;
						st_next.core.prod = signedProd;
						st_next.core.flagZ = (accSat == 32'h00000000);
						st_next.core.flagN = accSat[31];
						st_next.core.flagC = sum33[32];
						if (posOvf || negOvf) begin
							st_next.core.flagV = 1'b1;
						end
						if (!st_reg.core.saturate && posOvf) begin
							st_next.core.tally = st_reg.core.tally + 6'h01;
						end else if (!st_reg.core.saturate && negOvf) begin
							st_next.core.tally = st_reg.core.tally - 6'h01;
						end
					end
					mad_pkg::MUL_BYTE_CONST_ACC_OP: begin
						st_next.core.acc   = byteProd;
						st_next.core.flagZ = (byteProd == 32'h00000000);
						st_next.core.flagN = byteProd[31];
					end
					mad_pkg::MUL_BYTE_CONST_PROD_OP: st_next.core.prod = byteProd;
					mad_pkg::MUL_UNSIGNED_OP: st_next.core.prod = unsignedProd;
					default: st_next.core.prod = st_reg.core.prod;
				endcase
				if (st_reg.core.repCount == 8'h00) begin
					st_next.core.state = mad_pkg::ST_IDLE;
				end else begin
					st_next.core.repCount = st_reg.core.repCount - 8'h01;
				end
			end
			default: st_next.core.state = mad_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_reg               <= '0;
			st_reg.core.state    <= mad_pkg::ST_IDLE;
			st_reg.core.shiftSel <= mad_pkg::RST_SHIFT_SEL;
			st_reg.core.op       <= mad_pkg::MUL_NONE_OP;
			st_reg.axi.arReady   <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign s_axi_awready = st_reg.axi.awReady;
	assign s_axi_wready  = st_reg.axi.wReady;
	assign s_axi_bvalid  = st_reg.axi.bValid;
	assign s_axi_bresp   = st_reg.axi.bResp;
	assign s_axi_arready = st_reg.axi.arReady;
	assign s_axi_rvalid  = st_reg.axi.rValid;
	assign s_axi_rdata   = st_reg.axi.rData;
	assign s_axi_rresp   = st_reg.axi.rResp;

	// ========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	logic        running;
	logic        accumOp;
	logic [31:0] expSum;
	logic [31:0] expDiff;
	assign running = (st_reg.core.state == mad_pkg::ST_RUN);
	assign accumOp = running && (st_reg.core.op == mad_pkg::MUL_ADD_PREV_OP || isSub);
	assign expSum  = st_reg.core.acc + shiftedProd;
	assign expDiff = st_reg.core.acc - shiftedProd;

	sequence seqRepStart;
		startRepeatable && st_reg.core.repCount == 8'h03;
	endsequence
	sequence seqFourPasses;
		running [*4] ##1 !running;
	endsequence

	AST_ADD_ACC: assert property (accumOp && !isSub && !posOvf && !negOvf |=>
		st_reg.core.acc == $past(expSum)) else $error("add-previous accumulator wrong");
	AST_SUB_ACC: assert property (accumOp && isSub && !posOvf && !negOvf |=>
		st_reg.core.acc == $past(expDiff)) else $error("subtract-previous accumulator wrong");
	AST_PROD_LOAD: assert property (accumOp |=>
		st_reg.core.prod == $past(signedProd)) else $error("product not loaded");
	AST_ZERO_FLAG: assert property (accumOp |=>
		st_reg.core.flagZ == (st_reg.core.acc == 32'h00000000)) else $error("zero flag wrong");
	AST_NEG_FLAG: assert property (accumOp |=> st_reg.core.flagN == st_reg.core.acc[31])
		else $error("negative flag wrong");
	AST_V_STICKY: assert property (accumOp && st_reg.core.flagV |=> st_reg.core.flagV)
		else $error("overflow flag cleared");
	AST_SAT_POS: assert property (accumOp && st_reg.core.saturate && posOvf |=>
		st_reg.core.acc == mad_pkg::SAT_POS) else $error("no positive saturation");
	AST_REPEAT: assert property (seqRepStart |=> seqFourPasses)
		else $error("repeat count not honoured");
	AST_ONCE: assert property (startCmd && !startRepeatable |=>
		running ##1 (!running && st_reg.core.repCount == 8'h00)) else $error("single form repeated");
	AST_MCAND: assert property (running |=> $stable(st_reg.core.mcand))
		else $error("multiplicand changed");
	AST_NO_FLAGS: assert property (running && st_reg.core.op == mad_pkg::MUL_UNSIGNED_OP |=>
		$stable({st_reg.core.flagZ, st_reg.core.flagN, st_reg.core.flagC, st_reg.core.flagV}))
		else $error("unsigned form touched flags");
endmodule
`default_nettype wire

// [mad_datapath_tb.sv]
/*
 * Self-checking bench of the multiply-accumulate datapath: corner cases, then seeded random commands.
 * Assumes mad_pkg, mad_datapath and mad_host are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module mad_datapath_tb;
	logic        clk, rstn, awValid, awReady, wValid, wReady, bValid, bReady;
	logic        arValid, arReady, rValid, rReady, mSat, mZ, mN, mC, mV;
	logic [5:0]  awAddr, arAddr, mTally;
	logic [31:0] wData, rData, mAcc, mProd, rv;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp, resp;
	logic [15:0] mMcand;
	logic [2:0]  mSel;
	int          nErrors, samplesChecked, seed, i;
	mad_datapath u_mad_datapath (
		.clk(clk), .rstn(rstn),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady)
	);
	mad_host u_mad_host (
		.clk(clk), .awAddr(awAddr), .awValid(awValid), .awReady(awReady), .wData(wData),
		.wStrb(wStrb), .wValid(wValid), .wReady(wReady), .bResp(bResp), .bValid(bValid),
		.bReady(bReady), .arAddr(arAddr), .arValid(arValid), .arReady(arReady),
		.rData(rData), .rResp(rResp), .rValid(rValid), .rReady(rReady)
	);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ========================================
	// helpers
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nErrors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tallyAndFinish();
		$display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic put(input logic [5:0] a, input logic [31:0] d);
		u_mad_host.wr(a, d, resp);
	endtask
	task automatic get(input logic [5:0] a);
		u_mad_host.rd(a, rv, resp);
	endtask
	// ========================================
	// reference model
	// zero-fill left, sign-fill right
	function automatic logic [31:0] shiftProd(input logic [31:0] p, input logic [2:0] s);
		if (s == 3'h0) return p << 1;
		return $signed(p) >>> (s - 3'h1);
	endfunction
	task automatic accStep(input logic sub, input logic [15:0] opnd);
		logic [31:0] x;
		logic [32:0] s;
		x = shiftProd(mProd, mSel) ^ {32{sub}};
		s = {1'b0, mAcc} + {1'b0, x} + {32'h0, sub};
		mC = s[32];
		if (mAcc[31] == x[31] && s[31] != mAcc[31]) begin
			mV = 1'b1;
			if (mSat) s[31:0] = s[31] ? mad_pkg::SAT_POS : mad_pkg::SAT_NEG;
			else mTally = mTally + (s[31] ? 6'h01 : 6'h3F);
		end
		mAcc = s[31:0];
		mZ = (mAcc == 32'h0);
		mN = mAcc[31];
		mProd = $signed(mMcand) * $signed(opnd);
	endtask
	// rep[8] arms the prefix with count rep[7:0]
	task automatic runCase(input logic [3:0] ctrl, input logic [15:0] mc, input logic [31:0] acc,
		input logic [31:0] prod, input logic [9:0] flg, input logic [8:0] rep, input logic [2:0] op,
		input logic [7:0] imm, input logic [15:0] opnd);
		int n;
		{mSat, mSel, mMcand, mAcc, mProd} = {ctrl, mc, acc, prod};
		{mTally, mV, mC, mN, mZ} = flg;
		n = (rep[8] && (op == 3'h1 || op == 3'h2)) ? int'(rep[7:0]) + 1 : 1;
		put(mad_pkg::OFF_CTRL, {28'h0, ctrl});
		put(mad_pkg::OFF_MCAND, {16'h0, mc});
		put(mad_pkg::OFF_ACC, acc);
		put(mad_pkg::OFF_PROD, prod);
		put(mad_pkg::OFF_FLAGS, {22'h0, flg});
		if (rep[8]) put(mad_pkg::OFF_REPEAT, {24'h0, rep[7:0]});
		put(mad_pkg::OFF_CMD, {opnd, imm, 5'h0, op});
		if (n > 12) begin
			put(mad_pkg::OFF_MCAND, 32'h00005555);
			chk("write while busy", {30'h0, resp}, {30'h0, mad_pkg::RESP_SLVERR});
		end
		case (op)
			mad_pkg::MUL_ADD_PREV_OP, mad_pkg::MUL_SUB_PREV_OP: for (int k = 0; k < n; k++) accStep(op[1], opnd);
			mad_pkg::MUL_BYTE_CONST_ACC_OP: begin
				mAcc = $signed(mMcand) * $signed({8'h00, imm});
				mZ = (mAcc == 32'h0);
				mN = mAcc[31];
			end
			mad_pkg::MUL_BYTE_CONST_PROD_OP: mProd = $signed(mMcand) * $signed({8'h00, imm});
			default: mProd = {16'h0, mMcand} * {16'h0, opnd};
		endcase
		rv = 32'h1;
		for (int k = 0; k < 200 && rv[0]; k++) get(mad_pkg::OFF_STATUS);
		chk("status", {16'h0, rv[15:0]}, 32'h0);
		get(mad_pkg::OFF_ACC);
		chk("accumulator", rv, mAcc);
		get(mad_pkg::OFF_PROD);
		chk("product", rv, mProd);
		get(mad_pkg::OFF_FLAGS);
		chk("flags", rv, {22'h0, mTally, mV, mC, mN, mZ});
		get(mad_pkg::OFF_MCAND);
		chk("multiplicand", rv, {16'h0, mc});
	endtask
	// ========================================
	// main sequence
	initial begin
		rstn = 1'b0;
		seed = 82;
		nErrors = 0;
		samplesChecked = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		get(mad_pkg::OFF_CTRL);
		chk("control reset", rv, {29'h0, mad_pkg::RST_SHIFT_SEL});
		get(mad_pkg::OFF_FLAGS);
		chk("flags reset", rv, 32'h0);
		get(6'h20);
		chk("unmapped read", {30'h0, resp}, {30'h0, mad_pkg::RESP_SLVERR});
		$display("reset and map test done");
		runCase(4'h1, 16'h0002, 32'h7FFFFFFF, 32'h1, 10'h000, 9'h000, 3'h1, 8'h00, 16'h0003);
		runCase(4'h9, 16'h0002, 32'h7FFFFFFF, 32'h1, 10'h000, 9'h000, 3'h1, 8'h00, 16'h0003);
		runCase(4'h9, 16'h0002, 32'h80000000, 32'h1, 10'h000, 9'h000, 3'h2, 8'h00, 16'h0003);
		runCase(4'h1, 16'h0002, 32'h80000000, 32'h1, 10'h000, 9'h000, 3'h2, 8'h00, 16'h0003);
		runCase(4'h1, 16'h8000, 32'h5, 32'h5, 10'h008, 9'h000, 3'h2, 8'h00, 16'h8000);
		runCase(4'h0, 16'h1234, 32'h0, 32'h40000001, 10'h000, 9'h000, 3'h1, 8'h00, 16'h0101);
		runCase(4'h7, 16'hFFFF, 32'h1, 32'h80000000, 10'h000, 9'h000, 3'h1, 8'h00, 16'h7FFF);
		runCase(4'h1, 16'hFFFF, 32'h7FFFFFF0, 32'h10, 10'h000, 9'h103, 3'h1, 8'h00, 16'h0020);
		runCase(4'h1, 16'hFF80, 32'h5, 32'h5, 10'h3FF, 9'h105, 3'h3, 8'hFF, 16'h0000);
		runCase(4'h1, 16'h8001, 32'h5, 32'h5, 10'h2A5, 9'h103, 3'h4, 8'h80, 16'h0000);
		runCase(4'h1, 16'hFFFF, 32'h5, 32'h5, 10'h15A, 9'h107, 3'h5, 8'h00, 16'hFFFF);
		runCase(4'h2, 16'h0101, 32'h0, 32'h10000, 10'h000, 9'h114, 3'h2, 8'h00, 16'h7FFF);
		$display("corner cases done");
		for (i = 0; i < 60; i++) begin
			rv = $random(seed);
			runCase(rv[3:0], $random(seed), $random(seed), $random(seed), rv[13:4], {rv[14], 5'h0, rv[17:15]},
				3'h1 + 3'($unsigned($random(seed)) % 5), rv[25:18], $random(seed));
		end
		$display("random test done");
		tallyAndFinish();
	end
	// the whole run needs some 25 us; a hang is cut at 400 us
	initial begin
		#400000;
		nErrors++;
		$display("Error watchdog expired before the tests ended");
		tallyAndFinish();
	end
endmodule
`default_nettype wire

// [mad_host.sv]
/*
 * AXI4-Lite host model that issues register writes and reads to the datapath.
 * Assumes it shares clk with the slave and that its tasks are entered just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module mad_host (
	input  wire logic        clk,
	output var  logic [5:0]  awAddr,
	output var  logic        awValid,
	input  wire logic        awReady,
	output var  logic [31:0] wData,
	output var  logic [3:0]  wStrb,
	output var  logic        wValid,
	input  wire logic        wReady,
	input  wire logic [1:0]  bResp,
	input  wire logic        bValid,
	output var  logic        bReady,
	output var  logic [5:0]  arAddr,
	output var  logic        arValid,
	input  wire logic        arReady,
	input  wire logic [31:0] rData,
	input  wire logic [1:0]  rResp,
	input  wire logic        rValid,
	output var  logic        rReady
);
	// ========================================
	// idle values
	initial begin
		awAddr = 6'h00;
		awValid = 1'b0;
		wData = 32'h0;
		wStrb = 4'hF;
		wValid = 1'b0;
		bReady = 1'b0;
		arAddr = 6'h00;
		arValid = 1'b0;
		rReady = 1'b0;
	end
	// ========================================
	// bus cycles
	// released payload is inverted so a slave that samples it late sees garbage, not the old value
	task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		logic awDone;
		logic wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		awAddr <= a;
		wData <= d;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge clk);
			if (awValid && awReady) begin
				awDone = 1'b1;
				awValid <= 1'b0;
				awAddr <= ~a;
			end
			if (wValid && wReady) begin
				wDone = 1'b1;
				wValid <= 1'b0;
				wData <= ~d;
			end
		end
		do @(posedge clk); while (!bValid);
		r = bResp;
		bReady <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do @(posedge clk); while (!arReady);
		arValid <= 1'b0;
		arAddr <= ~a;
		do @(posedge clk); while (!rValid);
		d = rData;
		r = rResp;
		rReady <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// [mad_pkg.sv]
/*
 * Shared constants and types of the multiply-accumulate datapath.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none
package mad_pkg;
	// ========================================
	// register map (byte addresses)
	localparam int          ADDR_W     = 6;
	localparam logic [5:0]  OFF_CTRL   = 6'h00;
	localparam logic [5:0]  OFF_MCAND  = 6'h04;
	localparam logic [5:0]  OFF_ACC    = 6'h08;
	localparam logic [5:0]  OFF_PROD   = 6'h0C;
	localparam logic [5:0]  OFF_FLAGS  = 6'h10;
	localparam logic [5:0]  OFF_REPEAT = 6'h14;
	localparam logic [5:0]  OFF_CMD    = 6'h18;
	localparam logic [5:0]  OFF_STATUS = 6'h1C;
	// ========================================
	// field positions
	localparam int CTRL_SHIFT_LSB   = 0;
	localparam int CTRL_SAT_BIT     = 3;
	localparam int FLAG_Z_BIT       = 0;
	localparam int FLAG_N_BIT       = 1;
	localparam int FLAG_C_BIT       = 2;
	localparam int FLAG_V_BIT       = 3;
	localparam int FLAG_TALLY_LSB   = 4;
	localparam int CMD_OP_LSB       = 0;
	localparam int CMD_IMM_LSB      = 8;
	localparam int CMD_OPND_LSB     = 16;
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_ARMED_BIT   = 1;
	localparam int STAT_COUNT_LSB   = 8;
	// ========================================
	// reset values and constants
	localparam logic [2:0]  RST_SHIFT_SEL = 3'h1;
	localparam logic [31:0] SAT_POS       = 32'h7FFFFFFF;
	localparam logic [31:0] SAT_NEG       = 32'h80000000;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// ========================================
	// types
	typedef enum logic [2:0] {
		MUL_NONE_OP            = 3'h0,
		MUL_ADD_PREV_OP        = 3'h1,
		MUL_SUB_PREV_OP        = 3'h2,
		MUL_BYTE_CONST_ACC_OP  = 3'h3,
		MUL_BYTE_CONST_PROD_OP = 3'h4,
		MUL_UNSIGNED_OP        = 3'h5
	} mad_op_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_RUN  = 2'b10
	} mad_fsm_e;
	typedef struct packed {
		logic        awReady;
		logic        wReady;
		logic        bValid;
		logic [1:0]  bResp;
		logic        arReady;
		logic        rValid;
		logic [1:0]  rResp;
		logic [31:0] rData;
		logic        awHeld;
		logic        wHeld;
		logic [5:0]  awAddr;
		logic [31:0] wData;
		logic [3:0]  wStrb;
	} mad_axi_s;
	typedef struct packed {
		mad_fsm_e    state;
		logic [2:0]  shiftSel;
		logic        saturate;
		logic [15:0] mcand;
		logic [31:0] acc;
		logic [31:0] prod;
		logic        flagZ;
		logic        flagN;
		logic        flagC;
		logic        flagV;
		logic [5:0]  tally;
		logic [7:0]  repCount;
		logic        armed;
		mad_op_e     op;
		logic [15:0] operand;
		logic [7:0]  imm;
	} mad_core_s;
	typedef struct packed {
		mad_axi_s  axi;
		mad_core_s core;
	} mad_state_s;
endpackage
`default_nettype wire
